// File: rtl/tlic_arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tlic_arb_if;
	logic [tlic_pkg::NUM_SRC-1:0] req_high;
	logic [tlic_pkg::NUM_SRC-1:0] req_low;
	logic grant_valid;
	logic grant_high;
	logic [tlic_pkg::IDX_W-1:0] grant_idx;
	modport requester (output req_high, output req_low,
		input grant_valid, input grant_high, input grant_idx);
	modport arbiter (input req_high, input req_low,
		output grant_valid, output grant_high, output grant_idx);
endinterface : tlic_arb_if
`default_nettype wire

// File: rtl/tlic_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module tlic_arbiter (
	tlic_arb_if.arbiter arb
);
	logic [tlic_pkg::IDX_W-1:0] idx_high;
	logic [tlic_pkg::IDX_W-1:0] idx_low;
	// ==========================================
	// fixed poll order: lowest index wins
	always_comb begin
		idx_high = '0;
		idx_low = '0;
		for (int i = tlic_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (arb.req_high[i]) begin
				idx_high = i[tlic_pkg::IDX_W-1:0];
			end
			if (arb.req_low[i]) begin
				idx_low = i[tlic_pkg::IDX_W-1:0];
			end
		end
	end
	// high level beats low whatever the poll position
	assign arb.grant_high = |arb.req_high;
	assign arb.grant_valid = (|arb.req_high) | (|arb.req_low);
	assign arb.grant_idx = arb.grant_high ? idx_high : idx_low;
endmodule : tlic_arbiter
`default_nettype wire

// File: rtl/tlic_pkg.sv
package tlic_pkg;
	// ==========================================
	// sizes
	localparam int NUM_SRC = 11;
	localparam int IDX_W = 4;
	// ==========================================
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'ha8;
	localparam logic [7:0] IDX_SECONDARY = 8'ha9;
	localparam logic [7:0] IDX_PRIORITY = 8'hb8;
	localparam logic [7:0] IDX_STATUS = 8'hc0;
	localparam logic [7:0] IDX_BIT_ACCESS = 8'hc1;
	// ==========================================
	// reset values
	localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] RST_PRIORITY = 8'h00;
	localparam logic [7:0] RST_SECONDARY = 8'ha0;
	// secondary register bits that hold state; bit 3 is kept zero
	localparam logic [7:0] SECONDARY_MASK = 8'h77;
	localparam logic [7:0] PRIORITY_MASK = 8'h7f;
	// ==========================================
	// field positions
	localparam int BIT_GLOBAL = 7;
	localparam int BIT_ACC_VALUE = 3;
	localparam int BIT_ACC_TARGET = 4;
	localparam int STS_GRANT_LSB = 2;
	// ==========================================
	// poll order, index 0 is served first within a level
	localparam logic [IDX_W-1:0] SRC_SUPPLY_MON = 4'h0;
	localparam logic [IDX_W-1:0] SRC_WATCHDOG = 4'h1;
	localparam logic [IDX_W-1:0] SRC_EXT0 = 4'h2;
	localparam logic [IDX_W-1:0] SRC_ADC = 4'h3;
	localparam logic [IDX_W-1:0] SRC_TIMER0 = 4'h4;
	localparam logic [IDX_W-1:0] SRC_EXT1 = 4'h5;
	localparam logic [IDX_W-1:0] SRC_TIMER1 = 4'h6;
	localparam logic [IDX_W-1:0] SRC_SERIAL = 4'h7;
	localparam logic [IDX_W-1:0] SRC_UART = 4'h8;
	localparam logic [IDX_W-1:0] SRC_TIMER2 = 4'h9;
	localparam logic [IDX_W-1:0] SRC_TICK = 4'ha;
	// vector per poll index
	localparam logic [15:0] VECTOR_TABLE [NUM_SRC] = '{
		16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
		16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
	// ==========================================
	// acceptance sequence
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PUSH = 3'b010,
		ST_LOAD = 3'b100
	} tlic_state_t;
endpackage : tlic_pkg

// File: rtl/tlic_top.sv
// Function
// - global enable bit gates maskable sources
// - per-source enable bits in primary register
// - per-source priority bits, bit seven reserved
// - secondary enables for tick, supply, serial
// - secondary priorities in bits six to four
// - high request preempts low service routine
// - simultaneous levels: high served first
// - no preemption within same level
// - fixed poll order inside a level
// - push program counter on acceptance
// - then load the source vector
// - watchdog may interrupt instead of reset
// - watchdog always high, ignores global enable
// - watchdog interrupt needs nonzero timeout
// - reset values 00h and a0h
// - bit access primary, byte access secondary
// - enable register at a8h, resets 00h
`timescale 1ns/1ps
`default_nettype none
module tlic_top #(
	parameter int TIMEOUT_W = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [tlic_pkg::NUM_SRC-1:0] src_request,
	input wire logic watchdog_irq_mode,
	input wire logic [TIMEOUT_W-1:0] watchdog_timeout,
	input wire logic [15:0] pc_current,
	input wire logic reti,
	output logic stack_push,
	output logic [15:0] push_data,
	output logic pc_load,
	output logic [15:0] pc_vector,
	output logic [tlic_pkg::NUM_SRC-1:0] src_accept
);
	// ==========================================
	// registers
	logic [7:0] irq_enable_ff;
	logic [7:0] priority_ff;
	logic [7:0] secondary_ff;
	logic [31:0] prdata_ff;
	logic [15:0] push_data_ff;
	logic [15:0] vector_ff;
	logic [tlic_pkg::NUM_SRC-1:0] accept_ff;
	logic [tlic_pkg::IDX_W-1:0] grant_idx_ff;
	logic grant_high_ff;
	logic in_high_ff;
	logic in_low_ff;
	tlic_pkg::tlic_state_t state_ff;
	tlic_pkg::tlic_state_t nxt_state;
	logic nxt_in_high;
	logic nxt_in_low;
	// ==========================================
	// bus decode
	logic [9:0] word_idx;
	logic setup_phase;
	logic wr_access;
	logic hit_enable;
	logic hit_secondary;
	logic hit_priority;
	logic hit_status;
	logic hit_bit_access;
	logic hit_any;
	logic [2:0] bit_sel;
	logic [7:0] bit_onehot;
	logic bit_value;
	logic bit_to_priority;
	logic [7:0] read_mux;
	assign word_idx = paddr[11:2];
	assign setup_phase = psel & ~penable;
	assign wr_access = psel & penable & pwrite & hit_any;
	assign hit_enable = word_idx == {2'b00, tlic_pkg::IDX_IRQ_ENABLE};
	assign hit_secondary = word_idx == {2'b00, tlic_pkg::IDX_SECONDARY};
	assign hit_priority = word_idx == {2'b00, tlic_pkg::IDX_PRIORITY};
	assign hit_status = word_idx == {2'b00, tlic_pkg::IDX_STATUS};
	assign hit_bit_access = word_idx == {2'b00, tlic_pkg::IDX_BIT_ACCESS};
	assign hit_any = hit_enable | hit_secondary | hit_priority | hit_status | hit_bit_access;
	assign bit_sel = pwdata[2:0];
	assign bit_onehot = 8'h01 << bit_sel;
	assign bit_value = pwdata[tlic_pkg::BIT_ACC_VALUE];
	assign bit_to_priority = pwdata[tlic_pkg::BIT_ACC_TARGET];
	assign read_mux = hit_enable ? irq_enable_ff
		: hit_secondary ? secondary_ff
		: hit_priority ? priority_ff
		: hit_status ? {1'b0, grant_idx_ff, state_ff != tlic_pkg::ST_IDLE, in_high_ff, in_low_ff}
		: 8'h00;
	// zero wait states; unmapped words answer with an error and read zero
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit_any;
	assign prdata = prdata_ff;
	// ==========================================
	// register writes
	// reset values
	// bit access reaches enable and priority only
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irq_enable_ff <= tlic_pkg::RST_IRQ_ENABLE;
		end else if (wr_access && hit_enable) begin
			irq_enable_ff <= pwdata[7:0];
		end else if (wr_access && hit_bit_access && !bit_to_priority) begin
			irq_enable_ff <= bit_value ? (irq_enable_ff | bit_onehot)
				: (irq_enable_ff & ~bit_onehot);
		end
	end
	// bit seven of priority reads zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			priority_ff <= tlic_pkg::RST_PRIORITY;
		end else if (wr_access && hit_priority) begin
			priority_ff <= pwdata[7:0] & tlic_pkg::PRIORITY_MASK;
		end else if (wr_access && hit_bit_access && bit_to_priority) begin
			priority_ff <= (bit_value ? (priority_ff | bit_onehot)
				: (priority_ff & ~bit_onehot)) & tlic_pkg::PRIORITY_MASK;
		end
	end
	// bit seven keeps its reset one; bit three stays zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			secondary_ff <= tlic_pkg::RST_SECONDARY;
		end else if (wr_access && hit_secondary) begin
			secondary_ff <= (pwdata[7:0] & tlic_pkg::SECONDARY_MASK)
				| (tlic_pkg::RST_SECONDARY & ~tlic_pkg::SECONDARY_MASK);
		end
	end
	// read data captured in setup so it stands through the access cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata_ff <= {24'h00_0000, pwrite ? 8'h00 : read_mux};
		end
	end
	// ==========================================
	// enables and priorities in poll order
	logic watchdog_live;
	logic [tlic_pkg::NUM_SRC-1:0] src_enable;
	logic [tlic_pkg::NUM_SRC-1:0] src_high;
	logic [tlic_pkg::NUM_SRC-1:0] src_pending;
	logic global_irq_enable;
	// watchdog requests only in interrupt mode
	assign watchdog_live = watchdog_irq_mode & (|watchdog_timeout);
	assign global_irq_enable = irq_enable_ff[tlic_pkg::BIT_GLOBAL];
	assign src_enable = {secondary_ff[2], irq_enable_ff[5], irq_enable_ff[4],
		secondary_ff[0], irq_enable_ff[3], irq_enable_ff[2], irq_enable_ff[1],
		irq_enable_ff[6], irq_enable_ff[0], watchdog_live, secondary_ff[1]};
	// priority by poll index, watchdog fixed high
	assign src_high = {secondary_ff[6], priority_ff[5], priority_ff[4],
		secondary_ff[4], priority_ff[3], priority_ff[2], priority_ff[1],
		priority_ff[6], priority_ff[0], 1'b1, secondary_ff[5]};
	// ==========================================
	// pending set, gated by level in service
	tlic_arb_if arb_bus ();
	logic [tlic_pkg::NUM_SRC-1:0] maskable;
	logic [tlic_pkg::NUM_SRC-1:0] global_gate;
	genvar g;
	generate
		for (g = 0; g < tlic_pkg::NUM_SRC; g++) begin : g_src
			assign maskable[g] = (g != int'(tlic_pkg::SRC_WATCHDOG));
			assign global_gate[g] = global_irq_enable | ~maskable[g];
			assign src_pending[g] = src_request[g] & src_enable[g] & global_gate[g];
		end
	endgenerate
	// high preempts low only; nothing preempts high
	assign arb_bus.req_high = (in_high_ff || state_ff != tlic_pkg::ST_IDLE)
		? '0 : (src_pending & src_high);
	assign arb_bus.req_low = (in_high_ff || in_low_ff || state_ff != tlic_pkg::ST_IDLE)
		? '0 : (src_pending & ~src_high);
	tlic_arbiter u_arbiter (
		.arb(arb_bus.arbiter)
	);
	logic [15:0] rom_vector;
	tlic_vector_rom u_vector_rom (
		.src_idx(grant_idx_ff),
		.vector(rom_vector)
	);
	// ==========================================
	// acceptance sequence: idle, push, load
	logic take;
	assign take = (state_ff == tlic_pkg::ST_IDLE) && arb_bus.grant_valid;
	always_comb begin
		nxt_state = state_ff;
		nxt_in_high = in_high_ff;
		nxt_in_low = in_low_ff;
		case (state_ff)
			tlic_pkg::ST_IDLE: begin
				if (take) begin
					nxt_state = tlic_pkg::ST_PUSH;
				end
				// reti counts only here; one during push or load is dropped
				if (reti) begin
					if (in_high_ff) begin
						nxt_in_high = 1'b0;
					end else begin
						nxt_in_low = 1'b0;
					end
				end
			end
			// push comes before the vector load
			tlic_pkg::ST_PUSH: begin
				nxt_state = tlic_pkg::ST_LOAD;
			end
			// load marks the level in service
			tlic_pkg::ST_LOAD: begin
				nxt_state = tlic_pkg::ST_IDLE;
				if (grant_high_ff) begin
					nxt_in_high = 1'b1;
				end else begin
					nxt_in_low = 1'b1;
				end
			end
			default: begin
				nxt_state = tlic_pkg::ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_ff <= tlic_pkg::ST_IDLE;
			in_high_ff <= 1'b0;
			in_low_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			in_high_ff <= nxt_in_high;
			in_low_ff <= nxt_in_low;
		end
	end
	// grant and program counter frozen at acceptance
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			grant_idx_ff <= '0;
			grant_high_ff <= 1'b0;
			push_data_ff <= 16'h0000;
		end else if (take) begin
			grant_idx_ff <= arb_bus.grant_idx;
			grant_high_ff <= arb_bus.grant_high;
			push_data_ff <= pc_current;
		end
	end
	// acknowledge rides with the load so a source clears only once its vector is taken
	// vector and source acknowledge ready for the load cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			vector_ff <= 16'h0000;
			accept_ff <= '0;
		end else if (state_ff == tlic_pkg::ST_PUSH) begin
			vector_ff <= rom_vector;
			accept_ff <= tlic_pkg::NUM_SRC'(1) << grant_idx_ff;
		end else begin
			accept_ff <= '0;
		end
	end
	assign stack_push = state_ff == tlic_pkg::ST_PUSH;
	assign push_data = push_data_ff;
	assign pc_load = state_ff == tlic_pkg::ST_LOAD;
	assign pc_vector = vector_ff;
	assign src_accept = accept_ff;
	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_take;
		state_ff == tlic_pkg::ST_IDLE && arb_bus.grant_valid;
	endsequence
	sequence s_push_load;
		stack_push ##1 pc_load;
	endsequence
	a_push_then_load: assert property (s_take |=> s_push_load)
		else $error("push not followed by load");
	a_vector_value: assert property (pc_load |-> pc_vector == tlic_pkg::VECTOR_TABLE[grant_idx_ff])
		else $error("wrong vector loaded");
	a_pc_pushed: assert property (s_take ##1 stack_push |-> push_data == $past(pc_current))
		else $error("pushed value not the program counter");
	a_global_gate: assert property (!global_irq_enable && !watchdog_live |-> !arb_bus.grant_valid)
		else $error("grant with global enable off");
	a_wdt_unmasked: assert property (state_ff == tlic_pkg::ST_IDLE && !in_high_ff
		&& watchdog_live && src_request[tlic_pkg::SRC_WATCHDOG] |-> arb_bus.grant_high)
		else $error("watchdog not granted high");
	a_wdt_timeout: assert property (watchdog_timeout == '0 |-> !src_pending[tlic_pkg::SRC_WATCHDOG])
		else $error("watchdog pending with zero timeout");
	a_no_same_level: assert property (in_high_ff |-> !arb_bus.grant_valid)
		else $error("preemption inside high level");
	a_high_first: assert property (arb_bus.grant_valid && |(arb_bus.req_high) |-> arb_bus.grant_high)
		else $error("low level chosen over high");
	a_poll_order: assert property (arb_bus.grant_valid && arb_bus.grant_high |->
		(arb_bus.req_high & ((tlic_pkg::NUM_SRC'(1) << arb_bus.grant_idx) - 1'b1)) == '0)
		else $error("poll order violated");
	a_preempt_low: assert property (in_low_ff && !in_high_ff
		&& state_ff == tlic_pkg::ST_IDLE && |(src_pending & src_high) |=> stack_push)
		else $error("high request did not preempt");
	a_bit_three: assert property (secondary_ff[3] == 1'b0)
		else $error("secondary bit three set");
	a_enable_written: assert property (wr_access && hit_enable |=> irq_enable_ff == $past(pwdata[7:0]))
		else $error("enable write lost");
	// ==========================================
	// register contents and entry sequence
	// a stuck level flag would silence a whole priority level, so both ends of the high flag are watched
	sequence s_load_high;
		pc_load && grant_high_ff;
	endsequence
	sequence s_reti_high;
		state_ff == tlic_pkg::ST_IDLE && reti && in_high_ff;
	endsequence
	a_push_single: assert property (stack_push |=> !stack_push)
		else $error("push held longer than one cycle");
	a_accept_pulse: assert property (|src_accept |-> pc_load)
		else $error("source acknowledge outside the load cycle");
	a_load_level: assert property (s_load_high |=> in_high_ff)
		else $error("high level not marked in service");
	a_reti_pops: assert property (s_reti_high |=> !in_high_ff && in_low_ff == $past(in_low_ff))
		else $error("return did not pop the high level");
	a_low_blocked: assert property (in_low_ff && state_ff == tlic_pkg::ST_IDLE
		&& !(|(src_pending & src_high)) |-> !arb_bus.grant_valid)
		else $error("low request preempted low routine");
	a_masked_off: assert property (!global_irq_enable |->
		(src_pending & ~(tlic_pkg::NUM_SRC'(1) << tlic_pkg::SRC_WATCHDOG)) == '0)
		else $error("maskable source pending with global enable off");
	a_prio_reserved: assert property (priority_ff[7] == 1'b0)
		else $error("priority bit seven set");
	a_prio_write: assert property (wr_access && hit_priority |=>
		priority_ff == ($past(pwdata[7:0]) & tlic_pkg::PRIORITY_MASK))
		else $error("priority write lost");
	a_secondary_write: assert property (wr_access && hit_secondary |=>
		secondary_ff[6:4] == $past(pwdata[6:4])
		&& secondary_ff[2:0] == $past(pwdata[2:0]))
		else $error("secondary write lost");
	a_top_bit_set: assert property (secondary_ff[7] == 1'b1)
		else $error("secondary bit seven lost its reset value");
endmodule : tlic_top
`default_nettype wire

// File: rtl/tlic_vector_rom.sv
`timescale 1ns/1ps
`default_nettype none
module tlic_vector_rom (
	input wire logic [tlic_pkg::IDX_W-1:0] src_idx,
	output logic [15:0] vector
);
	// out-of-range index falls back to the first entry
	assign vector = (src_idx < tlic_pkg::IDX_W'(tlic_pkg::NUM_SRC))
		? tlic_pkg::VECTOR_TABLE[src_idx] : tlic_pkg::VECTOR_TABLE[0];
endmodule : tlic_vector_rom
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, reti, ret_cmd;
	logic stack_push, pc_load, wd_mode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] wd_to;
	logic [15:0] pc_current, push_data, pc_vector;
	logic [10:0] src_request, src_accept, raise;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [15:0] vt [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
		16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
	// ==========================================
	// instances
	tlic_top u_tlic_top (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_request(src_request), .watchdog_irq_mode(wd_mode),
		.watchdog_timeout(wd_to), .pc_current(pc_current), .reti(reti),
		.stack_push(stack_push), .push_data(push_data), .pc_load(pc_load),
		.pc_vector(pc_vector), .src_accept(src_accept));
	tlic_core_model u_tlic_core_model (.clk(clk), .reset_n(reset_n), .raise(raise),
		.ret_cmd(ret_cmd), .pc_load(pc_load), .pc_vector(pc_vector),
		.src_accept(src_accept), .src_request(src_request), .reti(reti),
		.pc_current(pc_current));
	// ==========================================
	// helpers
	task automatic end_sim();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		// no slave latency assumed; only the bench timeout ends a wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] d;
		logic e;
		apb(1'b1, idx, v, d, e);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		logic e;
		apb(1'b0, idx, 8'h00, d, e);
		check(d, exp);
	endtask : rd
	task automatic up(input logic [10:0] b);
		@(posedge clk);
		raise <= b;
		@(posedge clk);
		raise <= '0;
	endtask : up
	task automatic ret();
		@(posedge clk);
		ret_cmd <= 1'b1;
		@(posedge clk);
		ret_cmd <= 1'b0;
	endtask : ret
	task automatic none();
		repeat (8) begin
			@(posedge clk);
			check(32'(stack_push), 32'h0);
		end
	endtask : none
	task automatic serve(input int idx, input logic [15:0] vec);
		int n;
		n = 0;
		while (stack_push !== 1'b1 && n < 30) begin
			@(posedge clk);
			n++;
		end
		check(32'(stack_push), 32'h1);
		check(32'(push_data), 32'(pc_current));
		@(posedge clk);
		check(32'(pc_load), 32'h1);
		check(32'(pc_vector), 32'(vec));
		check(32'(src_accept), 32'h1 << idx);
	endtask : serve
	// ==========================================
	// scenarios
	task automatic t_regs();
		logic [31:0] d;
		logic e;
		rd(tlic_pkg::IDX_IRQ_ENABLE, 32'h0);
		rd(tlic_pkg::IDX_PRIORITY, 32'h0);
		rd(tlic_pkg::IDX_SECONDARY, 32'ha0);
		wr(tlic_pkg::IDX_PRIORITY, 8'hff);
		rd(tlic_pkg::IDX_PRIORITY, 32'h7f);
		wr(tlic_pkg::IDX_SECONDARY, 8'h77);
		rd(tlic_pkg::IDX_SECONDARY, 32'hf7);
		apb(1'b0, 8'h10, 8'h00, d, e);
		check(32'(e), 32'h1);
		check(d, 32'h0);
		check(32'(pready), 32'h1);
		wr(tlic_pkg::IDX_PRIORITY, 8'h00);
		wr(tlic_pkg::IDX_BIT_ACCESS, 8'h0a);
		rd(tlic_pkg::IDX_IRQ_ENABLE, 32'h04);
		wr(tlic_pkg::IDX_BIT_ACCESS, 8'h1e);
		rd(tlic_pkg::IDX_PRIORITY, 32'h40);
		rd(tlic_pkg::IDX_SECONDARY, 32'hf7);
		wr(tlic_pkg::IDX_PRIORITY, 8'h00);
		wr(tlic_pkg::IDX_SECONDARY, 8'h00);
	endtask : t_regs
	task automatic t_gate();
		wr(tlic_pkg::IDX_IRQ_ENABLE, 8'h01);
		wd_mode <= 1'b1;
		up(11'h006);
		none();
		wd_to <= 4'h3;
		serve(1, 16'h005b);
		ret();
		none();
		wr(tlic_pkg::IDX_IRQ_ENABLE, 8'h81);
		serve(2, 16'h0003);
		ret();
	endtask : t_gate
	task automatic t_poll();
		wr(tlic_pkg::IDX_IRQ_ENABLE, 8'hff);
		wr(tlic_pkg::IDX_SECONDARY, 8'h07);
		up(11'h7ff);
		serve(1, 16'h005b);
		ret();
		for (int i = 0; i < 11; i++) begin
			if (i != 1) begin
				serve(i, vt[i]);
				ret();
			end
		end
	endtask : t_poll
	task automatic t_preempt();
		wd_mode <= 1'b0;
		wr(tlic_pkg::IDX_IRQ_ENABLE, 8'h87);
		wr(tlic_pkg::IDX_PRIORITY, 8'h04);
		wr(tlic_pkg::IDX_SECONDARY, 8'h00);
		up(11'h004);
		serve(2, 16'h0003);
		rd(tlic_pkg::IDX_STATUS, 32'h11);
		up(11'h010);
		none();
		up(11'h020);
		serve(5, 16'h0013);
		ret();
		none();
		ret();
		serve(4, 16'h000b);
		ret();
	endtask : t_preempt
	task automatic t_levels();
		wr(tlic_pkg::IDX_IRQ_ENABLE, 8'h80);
		wr(tlic_pkg::IDX_SECONDARY, 8'h46);
		up(11'h401);
		serve(10, 16'h0053);
		ret();
		serve(0, 16'h0043);
		ret();
		up(11'h002);
		none();
	endtask : t_levels
	task automatic t_reset();
		wr(tlic_pkg::IDX_IRQ_ENABLE, 8'hff);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(tlic_pkg::IDX_IRQ_ENABLE, 32'h0);
		rd(tlic_pkg::IDX_PRIORITY, 32'h0);
		rd(tlic_pkg::IDX_SECONDARY, 32'ha0);
	endtask : t_reset
	// ==========================================
	// clock, watchdog on runaway, main sequence
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		{reset_n, psel, penable, pwrite, ret_cmd, wd_mode} = '0;
		{paddr, pwdata, wd_to, raise} = '0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_gate();
		t_poll();
		t_preempt();
		t_levels();
		t_reset();
		end_sim();
	end
endmodule : tb_top
`default_nettype wire

// File: tb/tlic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// core and request sources beside the controller
module tlic_core_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [tlic_pkg::NUM_SRC-1:0] raise,
	input wire logic ret_cmd,
	input wire logic pc_load,
	input wire logic [15:0] pc_vector,
	input wire logic [tlic_pkg::NUM_SRC-1:0] src_accept,
	output logic [tlic_pkg::NUM_SRC-1:0] src_request,
	output logic reti,
	output logic [15:0] pc_current
);
	// requests are levels held until accepted, so a refused one stays pending
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			src_request <= '0;
			pc_current <= 16'h1230;
		end else begin
			src_request <= (src_request & ~src_accept) | raise;
			// core jumps to the vector it is handed
			if (pc_load) begin
				pc_current <= pc_vector;
			end
		end
	end
	assign reti = ret_cmd;
endmodule : tlic_core_model
`default_nettype wire
